// [rtl/cuc_ctrl_reg.v]
// Coherency unit control register with standby, routing and linefill control
`include "cuc_map.vh"

module cuc_ctrl_reg (
  mclk,
  nrst,
  clkEn,
  regSel,
  regWr,
  regRd,
  regAddr,
  regByteEn,
  regWdata,
  regNonSecure,
  regCpuId,
  regRdata,
  sacBits,
  snsacBits,
  filterEnableIn,
  irqPending,
  cpuReqOutstanding,
  cpuWfi,
  unitBusy,
  accelArValid,
  accelAwValid,
  accelWValid,
  accelArReadyCore,
  accelAwReadyCore,
  accelWReadyCore,
  accelReadAddrReady,
  accelWriteAddrReady,
  accelWriteDataReady,
  intcClkRun,
  unitClkRun,
  srcValid,
  srcCache,
  srcFilterHit,
  srcPortOne,
  fillReq,
  fillReady,
  lookupDone,
  lookupMiss,
  l2SpecFill,
  l2ConfirmFill,
  unitEnable,
  parityEnable,
  filterActive
);
  parameter PARITY_IMPL = 1;
  parameter DUAL_MASTER = 1;

  input  wire                                  mclk;
  input  wire                                  nrst;
  input  wire                                  clkEn;
  input  wire                                  regSel;
  input  wire                                  regWr;
  input  wire                                  regRd;
  input  wire [`CUC_ADDR_W-1:0]                regAddr;
  input  wire [3:0]                            regByteEn;
  input  wire [31:0]                           regWdata;
  input  wire                                  regNonSecure;
  input  wire [`CUC_CPU_ID_W-1:0]              regCpuId;
  output reg  [31:0]                           regRdata;
  input  wire [`CUC_NCPU-1:0]                  sacBits;
  input  wire [`CUC_NCPU-1:0]                  snsacBits;
  input  wire                                  filterEnableIn;
  input  wire                                  irqPending;
  input  wire [`CUC_NCPU-1:0]                  cpuReqOutstanding;
  input  wire [`CUC_NCPU-1:0]                  cpuWfi;
  input  wire                                  unitBusy;
  input  wire                                  accelArValid;
  input  wire                                  accelAwValid;
  input  wire                                  accelWValid;
  input  wire                                  accelArReadyCore;
  input  wire                                  accelAwReadyCore;
  input  wire                                  accelWReadyCore;
  output wire                                  accelReadAddrReady;
  output wire                                  accelWriteAddrReady;
  output wire                                  accelWriteDataReady;
  output wire                                  intcClkRun;
  output wire                                  unitClkRun;
  input  wire [`CUC_NSRC-1:0]                  srcValid;
  input  wire [`CUC_NSRC*`CUC_CACHE_W-1:0]     srcCache;
  input  wire [`CUC_NSRC-1:0]                  srcFilterHit;
  output wire [`CUC_NSRC-1:0]                  srcPortOne;
  input  wire                                  fillReq;
  output wire                                  fillReady;
  input  wire                                  lookupDone;
  input  wire                                  lookupMiss;
  output wire                                  l2SpecFill;
  output wire                                  l2ConfirmFill;
  output wire                                  unitEnable;
  output wire                                  parityEnable;
  output wire                                  filterActive;

  // Stored fields; bits above the implemented width do not exist
  reg  [`CUC_CTRL_W-1:0] ctrl_q;
  reg  [`CUC_CTRL_W-1:0] ctrl_d;
  reg                    strapDone_q;
  wire [`CUC_CTRL_W-1:0] ctrlView;
  wire [`CUC_CTRL_W-1:0] wrMask;
  wire                   hit;
  wire                   wrAllowed;
  wire                   wrTake;
  wire                   allWfi;
  wire                   accelReq;
  wire                   unitGated;
  // Decoded conditions and named field views
  wire [`CUC_CTRL_W-1:0] wrNext;
  reg  [31:0]            rdNext;
  wire                   secureOk;
  wire                   nonSecureOk;
  wire                   intcIdle;
  wire                   intcWake;
  wire                   unitIdle;
  wire                   unitWake;
  wire                   intcGateBit;
  wire                   unitGateBit;
  wire                   port0Bit;
  wire                   specBit;
  wire [2:0]             readyCore;
  wire [2:0]             readyOut;

  // Decode: one register at offset zero
  assign hit = regSel && (regAddr == `CUC_CTRL_OFFSET);

  // Secure writes need the core's secure bit, non-secure ones both bits
  assign secureOk    = sacBits[regCpuId];
  assign nonSecureOk = secureOk && snsacBits[regCpuId];
  assign wrAllowed   = regNonSecure ? nonSecureOk : secureOk;
  assign wrTake      = hit && regWr && regByteEn[0] && wrAllowed;

  // Fields absent from the build cannot be written
  assign wrMask = {{(`CUC_CTRL_W-3){1'b1}},
                   (PARITY_IMPL != 0),
                   (DUAL_MASTER != 0),
                   1'b1};

  // Per-bit write merge; a field the build lacks keeps its stored value
  genvar b;
  generate
    for (b = 0; b < `CUC_CTRL_W; b = b + 1) begin : g_field
      assign wrNext[b] = wrMask[b] ? regWdata[b] : ctrl_q[b];
    end
  endgenerate

  // Next value; only byte lane zero carries implemented bits
  always @* begin
    ctrl_d = ctrl_q;
    if (!strapDone_q) begin
      // First enabled edge after release takes the filter strap
      ctrl_d[`CUC_BIT_FILTER] = filterEnableIn && (DUAL_MASTER != 0);
    end else if (wrTake) begin
      ctrl_d = wrNext;
    end
  end

  // Reset takes constants only; the strap is caught afterwards
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q      <= `CUC_CTRL_RESET;
      strapDone_q <= 1'b0;
    end else if (clkEn) begin
      ctrl_q      <= ctrl_d;
      strapDone_q <= 1'b1;
    end
  end

  // Read view forces unbuilt fields to zero
  assign ctrlView = ctrl_q & wrMask;

  // Read mux; unmapped offsets and reserved bits read zero
  always @* begin
    rdNext = 32'h00000000;
    if (hit) begin
      rdNext = {{`CUC_RSVD_W{1'b0}}, ctrlView};
    end
  end

  // Read data registered so it holds until the next read
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 32'h00000000;
    end else if (clkEn) begin
      if (regSel && regRd) begin
        regRdata <= rdNext;
      end
    end
  end

  // Named views of the control fields used below
  assign intcGateBit = ctrlView[`CUC_BIT_INTC_GATE];
  assign unitGateBit = ctrlView[`CUC_BIT_UNIT_GATE];
  assign port0Bit    = ctrlView[`CUC_BIT_PORT0];
  assign specBit     = ctrlView[`CUC_BIT_SPEC];

  // Field outputs; bit zero is a disable bit as printed
  assign unitEnable   = !ctrlView[`CUC_BIT_UNIT_DIS];
  assign parityEnable = ctrlView[`CUC_BIT_PARITY];
  assign filterActive = ctrlView[`CUC_BIT_FILTER];

  // Interrupt controller idles with nothing pending and no core access
  assign intcIdle = !irqPending && !(|cpuReqOutstanding);
  assign intcWake = !intcIdle;

  // Interrupt controller standby
  cuc_standby u_intcStandby (
    .mclk       (mclk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .gateEnable (intcGateBit),
    .idle       (intcIdle),
    .wake       (intcWake),
    .clkRun     (intcClkRun),
    .gated      ()
  );

  // Unit standby: waits for all cores idle and no port traffic
  assign allWfi   = &cpuWfi;
  assign accelReq = accelArValid || accelAwValid || accelWValid;

  // Unit idles once every core waits and port and pipeline are quiet; any
  // port request wakes it, trading one lost cycle for a simple wake path
  assign unitIdle = allWfi && !accelReq && !unitBusy;
  assign unitWake = !allWfi || accelReq;

  cuc_standby u_unitStandby (
    .mclk       (mclk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .gateEnable (unitGateBit),
    .idle       (unitIdle),
    .wake       (unitWake),
    .clkRun     (unitClkRun),
    .gated      (unitGated)
  );

  // Ready stays low while the standby state is gated, after the clock restarts; a request
  // raises wake, so the port loses at most the cycle of arrival
  assign readyCore = {accelWReadyCore, accelAwReadyCore, accelArReadyCore};
  genvar r;
  generate
    for (r = 0; r < 3; r = r + 1) begin : g_ready
      assign readyOut[r] = readyCore[r] && !unitGated;
    end
  endgenerate

  // Port readies in read address, write address, write data order
  assign accelReadAddrReady  = readyOut[0];
  assign accelWriteAddrReady = readyOut[1];
  assign accelWriteDataReady = readyOut[2];

  // Per-source routing: forced device traffic beats filtering
  genvar s;
  generate
    for (s = 0; s < `CUC_NSRC; s = s + 1) begin : g_route
      wire ncBuf;
      wire forceZero;
      wire filterRoute;
      // Noncacheable bufferable code marks device-type traffic
      assign ncBuf         = (srcCache[s*`CUC_CACHE_W +: `CUC_CACHE_W] == `CUC_CACHE_NC_BUF);
      assign forceZero     = port0Bit && ncBuf;
      assign filterRoute   = srcValid[s] && filterActive && srcFilterHit[s];
      assign srcPortOne[s] = filterRoute && !forceZero;
    end
  endgenerate

  // Speculative linefill; only meaningful with a matching level-two cache
  cuc_linefill u_linefill (
    .mclk          (mclk),
    .nrst          (nrst),
    .clkEn         (clkEn),
    .specEnable    (specBit),
    .fillReq       (fillReq),
    .fillReady     (fillReady),
    .lookupDone    (lookupDone),
    .lookupMiss    (lookupMiss),
    .l2SpecFill    (l2SpecFill),
    .l2ConfirmFill (l2ConfirmFill)
  );
endmodule

// [rtl/cuc_linefill.v]
// Speculative linefill sequencer toward the level-2 controller
`include "cuc_map.vh"

module cuc_linefill (
  mclk,
  nrst,
  clkEn,
  specEnable,
  fillReq,
  fillReady,
  lookupDone,
  lookupMiss,
  l2SpecFill,
  l2ConfirmFill
);
  input  wire mclk;
  input  wire nrst;
  input  wire clkEn;
  input  wire specEnable;
  input  wire fillReq;
  output wire fillReady;
  input  wire lookupDone;
  input  wire lookupMiss;
  output wire l2SpecFill;
  output wire l2ConfirmFill;

  localparam LF_IDLE = `CUC_LF_IDLE;
  localparam LF_WAIT = `CUC_LF_WAIT;

  reg [1:0] state_q;
  reg [1:0] state_d;

  // One speculative fill in flight; waits for its tag lookup result
  always @* begin
    state_d = state_q;
    case (state_q)
      LF_IDLE: begin
        if (l2SpecFill) begin
          state_d = LF_WAIT;
        end
      end
      LF_WAIT: begin
        if (lookupDone) begin
          state_d = LF_IDLE;
        end
      end
      default: begin
        state_d = LF_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= LF_IDLE;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // Disabled: every request passes and nothing is sent speculatively
  assign fillReady     = !specEnable || (state_q == LF_IDLE);
  assign l2SpecFill    = specEnable && fillReq && (state_q == LF_IDLE);
  assign l2ConfirmFill = (state_q == LF_WAIT) && lookupDone && lookupMiss;
endmodule

// [rtl/cuc_standby.v]
// Clock standby controller: gates a clock when idle, restarts it on wake
`include "cuc_map.vh"

module cuc_standby (
  mclk,
  nrst,
  clkEn,
  gateEnable,
  idle,
  wake,
  clkRun,
  gated
);
  input  wire mclk;
  input  wire nrst;
  input  wire clkEn;
  input  wire gateEnable;
  input  wire idle;
  input  wire wake;
  output wire clkRun;
  output wire gated;

  localparam ST_RUN   = `CUC_ST_RUN;
  localparam ST_GATED = `CUC_ST_GATED;

  reg [1:0] state_q;
  reg [1:0] state_d;

  // Next state; clearing the enable leaves the gated state at the next enabled edge
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (gateEnable && idle && !wake) begin
          state_d = ST_GATED;
        end
      end
      ST_GATED: begin
        if (!gateEnable || wake) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
    end else if (clkEn) begin
      state_q <= state_d;
    end
  end

  // Wake and disable restart the clock combinationally; gated clears only at the next enabled edge
  assign gated  = (state_q == ST_GATED);
  assign clkRun = !gated || wake || !gateEnable;
endmodule

// [shared/cuc_map.vh]
// Offsets, field positions and reset values of the coherency unit control register
`ifndef CUC_MAP_VH
`define CUC_MAP_VH

// Register window
`define CUC_ADDR_W        8
`define CUC_CTRL_OFFSET   8'h00

// Field positions
`define CUC_BIT_UNIT_DIS  0
`define CUC_BIT_FILTER    1
`define CUC_BIT_PARITY    2
`define CUC_BIT_SPEC      3
`define CUC_BIT_PORT0     4
`define CUC_BIT_UNIT_GATE 5
`define CUC_BIT_INTC_GATE 6

// Implemented width and reset value; the filter bit is replaced by a strap
`define CUC_CTRL_W        7
`define CUC_CTRL_RESET    7'h01
`define CUC_RSVD_W        25

// Request sources: four processors, then the accelerator port
`define CUC_NCPU          4
`define CUC_NSRC          5
`define CUC_CPU_ID_W      2

// Cache attribute code for noncacheable bufferable traffic
`define CUC_CACHE_W       4
`define CUC_CACHE_NC_BUF  4'h1

// One-hot state codes
`define CUC_ST_RUN        2'h1
`define CUC_ST_GATED      2'h2
`define CUC_LF_IDLE       2'h1
`define CUC_LF_WAIT       2'h2

`endif

// [testbench/cuc_accel_master.sv]
// Accelerator port master model issuing read address requests
module cuc_accel_master (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        go,
  input  wire        ready,
  output logic       valid,
  output logic [7:0] accepted
);
  timeunit 1ns;
  timeprecision 1ns;

  // Request holds until ready is seen at an edge; a stalled port just waits
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      valid <= 1'b0;
      accepted <= 8'h00;
    end else if (valid && ready) begin
      valid <= 1'b0;
      accepted <= accepted + 8'h01;
    end else if (go) begin
      valid <= 1'b1;
    end
  end
endmodule

// [testbench/cuc_ctrl_monitor.sv]
// Concurrent checks on the coherency unit control register ports
module cuc_ctrl_monitor (
  input wire        mclk,
  input wire        nrst,
  input wire        clkEn,
  input wire        regSel,
  input wire        regWr,
  input wire        regRd,
  input wire [7:0]  regAddr,
  input wire        regNonSecure,
  input wire [1:0]  regCpuId,
  input wire [31:0] regRdata,
  input wire [3:0]  snsacBits,
  input wire [3:0]  cpuWfi,
  input wire        unitBusy,
  input wire        accelArValid,
  input wire        accelReadAddrReady,
  input wire        unitClkRun,
  input wire        irqPending,
  input wire [3:0]  cpuReqOutstanding,
  input wire        intcClkRun,
  input wire        fillReq,
  input wire        fillReady,
  input wire        lookupDone,
  input wire        lookupMiss,
  input wire        l2SpecFill,
  input wire        l2ConfirmFill,
  input wire        unitEnable,
  input wire        parityEnable
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle condition of the unit standby logic, with read address valid as the only port request
  wire idleNow = &cpuWfi && !unitBusy && !accelArValid;
  wire nsDrop = clkEn && regSel && regWr && regNonSecure && !snsacBits[regCpuId];

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Gating, waking and the read address ready output
  a_ready_gated: assert property (!unitClkRun |-> !accelReadAddrReady) else $error("ready while gated");
  a_gate_cause: assert property ($fell(unitClkRun) |-> $past(idleNow)) else $error("gated while busy");
  a_wake_restart: assert property ((accelArValid || !(&cpuWfi)) |-> unitClkRun) else $error("no wake");
  a_intc_wake: assert property ((irqPending || (|cpuReqOutstanding)) |-> intcClkRun) else $error("intc off");
  // Speculative and confirming fills
  a_spec_once: assert property (l2SpecFill |-> fillReq && fillReady) else $error("stray spec fill");
  a_spec_busy: assert property (l2SpecFill && clkEn |=> !fillReady && !l2SpecFill) else $error("no wait");
  a_confirm_miss: assert property (l2ConfirmFill |-> lookupDone && lookupMiss && !fillReady) else $error("bad confirm");
  // Register port refusals
  a_nonsec_drop: assert property (nsDrop |=> $stable(unitEnable) && $stable(parityEnable)) else $error("ns write");
  a_unmapped_rd: assert property (clkEn && regSel && regRd && regAddr != 8'h00 |=> regRdata == 32'h0)
    else $error("unmapped data");

  c_gated: cover property ($fell(unitClkRun));
  c_confirm: cover property (l2ConfirmFill);
  c_ns_drop: cover property (nsDrop);
endmodule

bind cuc_ctrl_reg cuc_ctrl_monitor mon_u (.*);

// [testbench/cuc_tb.sv]
// Self-checking bench for the coherency unit control register
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, nrst = 1'b0, clkEn = 1'b1, regSel = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic regNonSecure = 1'b0, filterEnableIn = 1'b1, irqPending = 1'b0, unitBusy = 1'b0, go = 1'b0;
  logic accelAwValid = 1'b0, accelWValid = 1'b0, accelArReadyCore = 1'b1, accelAwReadyCore = 1'b1;
  logic accelWReadyCore = 1'b1, fillReq = 1'b0, lookupDone = 1'b0, lookupMiss = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [3:0] regByteEn = 4'h1, sacBits = 4'hf, snsacBits = 4'h0, cpuReqOutstanding = 4'h0, cpuWfi = 4'h0;
  logic [1:0] regCpuId = 2'h0;
  logic [31:0] regWdata = 32'h0, d;
  logic [4:0] srcValid = 5'h00, srcFilterHit = 5'h00;
  logic [19:0] srcCache = 20'h00000;
  logic [6:0] expReg;
  logic ok;
  wire accelArValid, accelReadAddrReady, accelWriteAddrReady, accelWriteDataReady, intcClkRun, unitClkRun;
  wire fillReady, l2SpecFill, l2ConfirmFill, unitEnable, parityEnable, filterActive;
  wire [31:0] regRdata;
  wire [4:0] srcPortOne;
  wire [7:0] accepted;
  integer seed = 32'hd5f3, n_errors = 0, total_checks = 0, i;

  cuc_ctrl_reg dut_u (.*);
  cuc_accel_master acc_u (.mclk(mclk), .nrst(nrst), .go(go), .ready(accelReadAddrReady),
    .valid(accelArValid), .accepted(accepted));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  // One access cycle; read data is settled at the closing falling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(negedge mclk);
    regSel = 1'b1;
    regWr = w;
    regRd = !w;
    regAddr = a;
    regWdata = v;
    @(negedge mclk);
    regSel = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    acc(0, 8'h00, 0);
    chk("reset reg", 32'h3, regRdata);
    chk("enable", 0, unitEnable);
    chk("parity", 0, parityEnable);
    chk("filter", 1, filterActive);
    $display("reset test done");
    // Random writes with random access rights, lane enables and addresses
    expReg = 7'h03;
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      sacBits = d[11:8];
      snsacBits = d[15:12];
      regNonSecure = d[16];
      regCpuId = d[18:17];
      regByteEn = d[22:19];
      ok = sacBits[regCpuId] && (!regNonSecure || snsacBits[regCpuId]) && regByteEn[0] && !d[23];
      acc(1, {5'h0, d[23], 2'h0}, d);
      if (ok) expReg = d[6:0];
      acc(0, 8'h00, 0);
      chk("reg", {25'h0, expReg}, regRdata);
      acc(0, 8'h04, 0);
      chk("unmapped", 0, regRdata);
    end
    chk("parity out", expReg[2], parityEnable);
    regNonSecure = 1'b0;
    sacBits = 4'hf;
    regByteEn = 4'h1;
    $display("register test done");
    // Every cache code with the port-zero force on
    acc(1, 8'h00, 32'h12);
    srcValid = 5'h1f;
    srcFilterHit = 5'h1f;
    for (i = 0; i < 16; i++) begin
      @(negedge mclk);
      srcCache = {5{i[3:0]}};
      #1 chk("route", (i == 1) ? 32'h0 : 32'h1f, srcPortOne);
    end
    acc(1, 8'h00, 32'h10);
    chk("no filter", 0, srcPortOne);
    $display("routing test done");
    // Unit standby: gate, wake by the port, wake by a core, release by clearing
    acc(1, 8'h00, 32'h20);
    cpuWfi = 4'hf;
    repeat (2) @(negedge mclk);
    chk("gated", 0, unitClkRun);
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    chk("port wake", 1, unitClkRun);
    chk("ready low", 0, accelReadAddrReady);
    for (i = 0; i < 20 && accepted != 8'h01; i++) @(negedge mclk);
    chk("accepted", 1, accepted);
    if (i == 20) finish_test;
    repeat (2) @(negedge mclk);
    chk("regated", 0, unitClkRun);
    cpuWfi = 4'h7;
    #1 chk("core wake", 1, unitClkRun);
    @(negedge mclk);
    cpuWfi = 4'hf;
    repeat (2) @(negedge mclk);
    acc(1, 8'h00, 32'h00);
    chk("released", 1, unitClkRun);
    accelArReadyCore = 1'b0;
    #1 chk("core ready", 0, accelReadAddrReady);
    @(negedge mclk);
    accelArReadyCore = 1'b1;
    // Interrupt controller standby
    acc(1, 8'h00, 32'h40);
    @(negedge mclk);
    chk("intc off", 0, intcClkRun);
    irqPending = 1'b1;
    #1 chk("intc wake", 1, intcClkRun);
    @(negedge mclk);
    irqPending = 1'b0;
    @(negedge mclk);
    cpuReqOutstanding = 4'h4;
    #1 chk("intc access", 1, intcClkRun);
    @(negedge mclk);
    cpuReqOutstanding = 4'h0;
    $display("standby test done");
    // Speculative fill with miss, then with hit, then disabled
    acc(1, 8'h00, 32'h08);
    for (i = 0; i < 2; i++) begin
      fillReq = 1'b1;
      #1 chk("spec", 1, l2SpecFill);
      @(negedge mclk);
      fillReq = 1'b0;
      chk("busy", 0, fillReady);
      lookupDone = 1'b1;
      lookupMiss = !i[0];
      #1 chk("confirm", !i[0], l2ConfirmFill);
      @(negedge mclk);
      lookupDone = 1'b0;
      chk("free", 1, fillReady);
    end
    acc(1, 8'h00, 32'h00);
    fillReq = 1'b1;
    #1 chk("spec off", 0, l2SpecFill);
    @(negedge mclk);
    fillReq = 1'b0;
    $display("linefill test done");
    // Mid-run reset with the filter strap low; standby was gating beforehand
    acc(1, 8'h00, 32'h7e);
    acc(0, 8'h00, 0);
    chk("full byte", 32'h7e, regRdata);
    filterEnableIn = 1'b0;
    nrst = 1'b0;
    @(negedge mclk);
    chk("reset data", 0, regRdata);
    chk("reset enable", 0, unitEnable);
    chk("reset run", 1, unitClkRun);
    nrst = 1'b1;
    acc(0, 8'h00, 0);
    chk("strap low", 32'h1, regRdata);
    chk("strap off", 0, filterActive);
    $display("reset test two done");
    finish_test;
  end
endmodule
